// ### mpes_params.svh
// constants for the memory pipeline event select block
`ifndef MPES_PARAMS_SVH
`define MPES_PARAMS_SVH

// event codes
`define MPES_EV_RETRYQ 8'h03
`define MPES_EV_MEMUOP 8'h04
`define MPES_EV_WALK 8'h05
`define MPES_EV_L2CACHE 8'h2e
`define MPES_EV_XQREJ 8'h30
`define MPES_EV_L2QREJ 8'h31

// unit masks
`define MPES_UM_00 8'h00
`define MPES_UM_01 8'h01
`define MPES_UM_02 8'h02
`define MPES_UM_03 8'h03
`define MPES_UM_04 8'h04
`define MPES_UM_08 8'h08
`define MPES_UM_10 8'h10
`define MPES_UM_20 8'h20
`define MPES_UM_40 8'h40
`define MPES_UM_41 8'h41
`define MPES_UM_4F 8'h4f
`define MPES_UM_80 8'h80

// counter and queue sizing defaults
`define MPES_CNT_W 48
`define MPES_L2Q_DEPTH 8'h10
`define MPES_L2Q_MARGIN 8'h01
`define MPES_FAIR_SHARE 8'h0c
`define MPES_XQ_DEPTH 8'h08
`define MPES_XQ_MARGIN 8'h02
`define MPES_RQ_DEPTH 8'h08
`define MPES_LVL_ZERO 8'h00

`endif

// ### mpes_pkg.sv
// types shared by the memory pipeline event select block
package mpes_pkg;

  typedef logic [7:0] mpes_lvl_t;

  // per-cycle condition strobes from the core pipeline
  typedef struct packed {
    logic ld_fwd_blocked;
    logic ld_std_late;
    logic st_split;
    logic ld_split;
    logic lock_op;
    logic sta_full;
    logic reissue_ld;
    logic reissue_st;
    logic ld_l1_miss;
    logic ld_l2_hit;
    logic ld_l2_miss;
    logic ld_dtb_miss;
    logic ld_utb_miss;
    logic ld_remote_hit;
    logic ld_retired;
    logic st_retired;
    logic dwalk_busy;
    logic iwalk_busy;
    logic l2_miss;
    logic l2_ref;
  } mpes_mem_ev_s;

  // one request from either core into the shared queue
  typedef struct packed {
    logic valid;
    logic core;
    logic dirty_evict;
    logic addr_conflict;
    logic l2_pf;
    logic direct_xq;
  } mpes_req_s;

  // one second-level queue entry finishing its lookup
  typedef struct packed {
    logic valid;
    logic core;
    logic miss;
  } mpes_done_s;

endpackage

// ### mpes_queue_track.sv
// shared request queues and retry queue occupancy with reject events
`timescale 1ns/1ps
`default_nettype none
`include "mpes_params.svh"

module mpes_queue_track
  import mpes_pkg::*;
#(
  parameter mpes_lvl_t L2Q_DEPTH = `MPES_L2Q_DEPTH,
  parameter mpes_lvl_t L2Q_MARGIN = `MPES_L2Q_MARGIN,
  parameter mpes_lvl_t FAIR_SHARE = `MPES_FAIR_SHARE,
  parameter mpes_lvl_t XQ_DEPTH = `MPES_XQ_DEPTH,
  parameter mpes_lvl_t XQ_MARGIN = `MPES_XQ_MARGIN,
  parameter mpes_lvl_t RQ_DEPTH = `MPES_RQ_DEPTH
)(
  input wire logic mclk,
  input wire logic resetn,
  input wire mpes_req_s req,
  input wire mpes_done_s done,
  input wire logic xq_issue,
  input wire logic rq_park,
  input wire logic rq_done,
  output logic l2q_rej_r,
  output logic xq_rej_r,
  output mpes_lvl_t l2q_lvl_r,
  output mpes_lvl_t xq_lvl_r,
  output mpes_lvl_t rq_lvl_r
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  function automatic mpes_lvl_t lvl_step(mpes_lvl_t cur, logic inc,
                                         logic dec);
    lvl_step = cur + {7'h00, inc} - {7'h00, dec};
  endfunction

  mpes_lvl_t core_lvl_r [2];
  wire logic l2q_near;
  wire logic xq_near;
  wire logic share_over;
  wire logic evict_hit;
  wire logic req_rej;
  wire logic l2q_in;
  wire logic l2q_out;
  wire logic xq_move;
  wire logic xq_direct;
  wire logic xq_out;
  wire logic rq_in;
  wire logic rq_out;

  ////////////////////////////////////////////////////////////////////////
  // admission: full, fairness and dirty eviction conflict all reject
  assign l2q_near = l2q_lvl_r >= (L2Q_DEPTH - L2Q_MARGIN);
  assign xq_near = xq_lvl_r >= (XQ_DEPTH - XQ_MARGIN);
  assign share_over = core_lvl_r[req.core] >= FAIR_SHARE;
  assign evict_hit = req.dirty_evict & req.addr_conflict;
  assign req_rej = req.valid & (req.direct_xq ? xq_near
                 : (l2q_near | share_over | evict_hit));
  assign l2q_in = req.valid & ~req.direct_xq & ~req_rej;
  // a miss that finds the outer queue near full stays and retries
  assign xq_move = done.valid & done.miss & ~xq_near;
  assign l2q_out = done.valid & (~done.miss | ~xq_near);
  assign xq_direct = req.valid & req.direct_xq & ~xq_near;
  assign xq_out = xq_issue & (xq_lvl_r != `MPES_LVL_ZERO);
  // margin of two lets a move and a direct entry land together
  assign rq_in = rq_park & (rq_lvl_r != RQ_DEPTH);
  assign rq_out = rq_done & (rq_lvl_r != `MPES_LVL_ZERO);

  ////////////////////////////////////////////////////////////////////////
  // occupancy and reject pulses
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      l2q_lvl_r <= `MPES_LVL_ZERO;
      xq_lvl_r <= `MPES_LVL_ZERO;
      rq_lvl_r <= `MPES_LVL_ZERO;
      core_lvl_r[0] <= `MPES_LVL_ZERO;
      core_lvl_r[1] <= `MPES_LVL_ZERO;
      l2q_rej_r <= 1'b0;
      xq_rej_r <= 1'b0;
    end
    else
    begin
      l2q_lvl_r <= lvl_step(l2q_lvl_r, l2q_in, l2q_out);
      xq_lvl_r <= lvl_step(lvl_step(xq_lvl_r, xq_move, xq_out),
                           xq_direct, 1'b0);
      rq_lvl_r <= lvl_step(rq_lvl_r, rq_in, rq_out);
      for (int c = 0; c < 2; c++)
        core_lvl_r[c] <= lvl_step(core_lvl_r[c],
                                  l2q_in & (req.core == c[0]),
                                  l2q_out & (done.core == c[0]));
      // dropped second-level prefetches are not reported
      l2q_rej_r <= req_rej & ~req.l2_pf;
      xq_rej_r <= done.valid & done.miss & xq_near;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  rq_hold_a: assert property (!rq_park && !rq_done
      |=> $stable(rq_lvl_r))
    else $error("retry queue level moved without park or done");
  fair_rej_a: assert property (req.valid && !req.direct_xq
      && !req.l2_pf && share_over |=> l2q_rej_r)
    else $error("over-share request not rejected");
  // a rejected eviction must not take a slot in the shared queue
  evict_rej_a: assert property (req.valid && !req.direct_xq
      && !req.l2_pf && evict_hit
      |=> l2q_rej_r && l2q_lvl_r <= $past(l2q_lvl_r))
    else $error("conflicting dirty eviction accepted");
  xq_rej_a: assert property (done.valid && done.miss && xq_near
      |=> xq_rej_r ##1 !xq_rej_r || !$past(done.valid))
    else $error("outer queue reject not reported");

endmodule
`default_nettype wire

// ### mpes_src_model.sv
// far-side model: core pipeline and cache event and request sources
`timescale 1ns/1ps
`default_nettype none

module mpes_src_model
  import mpes_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [4:0] ev_idx,
  input wire logic ev_on,
  input wire mpes_req_s req_cmd,
  input wire mpes_done_s done_cmd,
  output mpes_mem_ev_s mem_ev,
  output mpes_req_s req,
  output mpes_done_s done
);
  // one-hot strobe; index 0 is the first struct member, the msb
  wire logic [19:0] sel_w = 20'h80000 >> ev_idx;

  //////////////////////////////////////////////////////////////////////////////
  // sources launch on the edge, like the real pipeline; idle strobes are low
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_ev <= '0;
      req <= '0;
      done <= '0;
    end
    else
    begin
      mem_ev <= ev_on ? mpes_mem_ev_s'(sel_w) : '0;
      req <= req_cmd;
      done <= done_cmd;
    end
  end
endmodule

`default_nettype wire

// ### mpes_top.sv
// memory pipeline event select and counter
// Summary of operation
// - 03H/01H counts loads denied forwarding, address mismatch
// - 03H/02H counts forwards lost to late store data
// - 03H/04H store splits, 08H load line splits
// - 03H/10H counts retired locked memory operations
// - 03H/20H counts stores delayed, store address full
// - 03H/40H reissued loads, 80H reissued stores
// - retry queue holds ops until reissued, completed
// - 04H/01H counts first-level load misses, no prefetch
// - 04H/02H second-level load hits, 04H misses
// - 04H/08H data buffer misses, 10H unified misses
// - 04H/20H loads supplied by other core
// - 04H/40H all retired loads, 80H all stores
// - 05H/01H data walk cycles, 02H instruction walks
// - 05H/03H with edge counts walks, else cycles
// - 2EH/41H second-level misses, 4FH references
// - 30H counts outer queue rejects of moving misses when near full
// - misses pass second-level queue then outer queue
// - both cores share both queues, outer nearest link
// - 31H counts shared queue rejects, not dropped prefetches
// - shared queue may reject a core for fairness
// - conflicting dirty eviction may be rejected with room
`timescale 1ns/1ps
`default_nettype none
`include "mpes_params.svh"

module mpes_top
  import mpes_pkg::*;
#(
  parameter int CNT_W = `MPES_CNT_W,
  parameter mpes_lvl_t L2Q_DEPTH = `MPES_L2Q_DEPTH,
  parameter mpes_lvl_t XQ_DEPTH = `MPES_XQ_DEPTH,
  parameter mpes_lvl_t RQ_DEPTH = `MPES_RQ_DEPTH
)(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] event_code,
  input wire logic [7:0] unit_mask,
  input wire logic edge_det,
  input wire logic count_en,
  input wire logic count_clr,
  input wire mpes_mem_ev_s mem_ev,
  input wire mpes_req_s req,
  input wire mpes_done_s done,
  input wire logic xq_issue,
  input wire logic rq_park,
  input wire logic rq_done,
  output logic [CNT_W-1:0] count_r,
  output logic hit_r,
  output logic l2q_rej_r,
  output logic xq_rej_r,
  output mpes_lvl_t l2q_lvl_r,
  output mpes_lvl_t xq_lvl_r,
  output mpes_lvl_t rq_lvl_r
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////
  // decode of one code and mask pair into the selected condition

  function automatic logic pick_cond(logic [7:0] code, logic [7:0] um,
                                     mpes_mem_ev_s ev, logic l2q_rej,
                                     logic xq_rej);
    logic c;
    c = 1'b0;
    if (code == `MPES_EV_RETRYQ)
    begin
      if (um == `MPES_UM_01)
        c = ev.ld_fwd_blocked;
      else if (um == `MPES_UM_02)
        c = ev.ld_std_late;
      else if (um == `MPES_UM_04)
        c = ev.st_split;
      else if (um == `MPES_UM_08)
        c = ev.ld_split;
      else if (um == `MPES_UM_10)
        c = ev.lock_op;
      else if (um == `MPES_UM_20)
        c = ev.sta_full;
      else if (um == `MPES_UM_40)
        c = ev.reissue_ld;
      else if (um == `MPES_UM_80)
        c = ev.reissue_st;
    end
    else if (code == `MPES_EV_MEMUOP)
    begin
      if (um == `MPES_UM_01)
        c = ev.ld_l1_miss;
      else if (um == `MPES_UM_02)
        c = ev.ld_l2_hit;
      else if (um == `MPES_UM_04)
        c = ev.ld_l2_miss;
      else if (um == `MPES_UM_08)
        c = ev.ld_dtb_miss;
      else if (um == `MPES_UM_10)
        c = ev.ld_utb_miss;
      else if (um == `MPES_UM_20)
        c = ev.ld_remote_hit;
      else if (um == `MPES_UM_40)
        c = ev.ld_retired;
      else if (um == `MPES_UM_80)
        c = ev.st_retired;
    end
    else if (code == `MPES_EV_WALK)
    begin
      if (um == `MPES_UM_01)
        c = ev.dwalk_busy;
      else if (um == `MPES_UM_02)
        c = ev.iwalk_busy;
      else if (um == `MPES_UM_03)
        c = ev.dwalk_busy | ev.iwalk_busy;
    end
    else if (code == `MPES_EV_L2CACHE)
    begin
      if (um == `MPES_UM_41)
        c = ev.l2_miss;
      else if (um == `MPES_UM_4F)
        c = ev.l2_ref;
    end
    else if (code == `MPES_EV_XQREJ && um == `MPES_UM_00)
      c = xq_rej;
    else if (code == `MPES_EV_L2QREJ && um == `MPES_UM_00)
      c = l2q_rej;
    pick_cond = c;
  endfunction

  // same decode with every strobe high tells whether the pair exists
  function automatic logic pick_known(logic [7:0] code, logic [7:0] um);
    mpes_mem_ev_s all;
    all = '1;
    pick_known = pick_cond(code, um, all, 1'b1, 1'b1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // shared request queues and retry queue

  mpes_queue_track #(
    .L2Q_DEPTH(L2Q_DEPTH),
    .L2Q_MARGIN(`MPES_L2Q_MARGIN),
    .FAIR_SHARE(`MPES_FAIR_SHARE),
    .XQ_DEPTH(XQ_DEPTH),
    .XQ_MARGIN(`MPES_XQ_MARGIN),
    .RQ_DEPTH(RQ_DEPTH)
  ) u_queue (
    .mclk(mclk),
    .resetn(resetn),
    .req(req),
    .done(done),
    .xq_issue(xq_issue),
    .rq_park(rq_park),
    .rq_done(rq_done),
    .l2q_rej_r(l2q_rej_r),
    .xq_rej_r(xq_rej_r),
    .l2q_lvl_r(l2q_lvl_r),
    .xq_lvl_r(xq_lvl_r),
    .rq_lvl_r(rq_lvl_r)
  );

  ////////////////////////////////////////////////////////////////////////
  // selection and edge qualification

  logic cond_prev_r;
  wire logic cond;
  wire logic code_known;
  wire logic inc;

  assign cond = pick_cond(event_code, unit_mask, mem_ev,
                          l2q_rej_r, xq_rej_r);
  assign code_known = pick_known(event_code, unit_mask);
  // edge mode needs the previous cycle low; level mode counts cycles
  assign inc = count_en & cond & (~edge_det | ~cond_prev_r);

  ////////////////////////////////////////////////////////////////////////
  // history of the selected condition, kept even while disabled
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cond_prev_r <= 1'b0;
    else
      cond_prev_r <= cond;
  end

  // counter wraps silently; overflow handling sits outside this block
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_r <= CNT_W'(0);
      hit_r <= 1'b0;
    end
    else
    begin
      hit_r <= inc;
      if (count_clr)
        count_r <= CNT_W'(0);
      else
        count_r <= count_r + {{(CNT_W-1){1'b0}}, inc};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks on selection and counting

  count_step_a: assert property (hit_r && !$past(count_clr)
      |-> count_r == $past(count_r) + 1'b1)
    else $error("hit without a single increment");
  count_still_a: assert property (!hit_r && !$past(count_clr)
      |-> $stable(count_r))
    else $error("counter moved with no hit");
  unknown_code_a: assert property (!code_known |=> !hit_r)
    else $error("unrecognised selection produced a hit");
  edge_once_a: assert property (edge_det && cond_prev_r |=> !hit_r)
    else $error("edge mode counted a held condition");
  level_every_a: assert property (count_en && !edge_det && cond
      [*3] |=> hit_r [*1])
    else $error("level mode skipped an active cycle");
  walk_edge_a: assert property (count_en && edge_det
      && event_code == `MPES_EV_WALK && unit_mask == `MPES_UM_03
      && (mem_ev.dwalk_busy || mem_ev.iwalk_busy) && !cond_prev_r
      |=> hit_r ##1 (!hit_r || !$past(edge_det) || !$past(cond_prev_r)))
    else $error("walk start not counted once");

  // each level-mode selection counts its own strobe one edge later;
  // a decode slip onto a neighbour strobe shows up as a missed hit
  ld_fwd_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_RETRYQ && unit_mask == `MPES_UM_01
      && mem_ev.ld_fwd_blocked |=> hit_r)
    else $error("blocked forward not counted");
  ld_late_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_RETRYQ && unit_mask == `MPES_UM_02
      && mem_ev.ld_std_late |=> hit_r)
    else $error("late store data not counted");
  st_split_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_RETRYQ && unit_mask == `MPES_UM_04
      && mem_ev.st_split |=> hit_r)
    else $error("store line split not counted");
  ld_split_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_RETRYQ && unit_mask == `MPES_UM_08
      && mem_ev.ld_split |=> hit_r)
    else $error("load line split not counted");
  lock_op_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_RETRYQ && unit_mask == `MPES_UM_10
      && mem_ev.lock_op |=> hit_r)
    else $error("locked operation not counted");
  sta_full_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_RETRYQ && unit_mask == `MPES_UM_20
      && mem_ev.sta_full |=> hit_r)
    else $error("store address stall not counted");
  reissue_ld_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_RETRYQ && unit_mask == `MPES_UM_40
      && mem_ev.reissue_ld |=> hit_r)
    else $error("reissued load not counted");
  reissue_st_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_RETRYQ && unit_mask == `MPES_UM_80
      && mem_ev.reissue_st |=> hit_r)
    else $error("reissued store not counted");
  l1_miss_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_MEMUOP && unit_mask == `MPES_UM_01
      && mem_ev.ld_l1_miss |=> hit_r)
    else $error("first-level load miss not counted");
  l2_hit_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_MEMUOP && unit_mask == `MPES_UM_02
      && mem_ev.ld_l2_hit |=> hit_r)
    else $error("second-level load hit not counted");
  l2_miss_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_MEMUOP && unit_mask == `MPES_UM_04
      && mem_ev.ld_l2_miss |=> hit_r)
    else $error("second-level load miss not counted");
  dtb_miss_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_MEMUOP && unit_mask == `MPES_UM_08
      && mem_ev.ld_dtb_miss |=> hit_r)
    else $error("data buffer miss not counted");
  utb_miss_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_MEMUOP && unit_mask == `MPES_UM_10
      && mem_ev.ld_utb_miss |=> hit_r)
    else $error("unified buffer miss not counted");
  remote_hit_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_MEMUOP && unit_mask == `MPES_UM_20
      && mem_ev.ld_remote_hit |=> hit_r)
    else $error("remote supplied load not counted");
  all_loads_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_MEMUOP && unit_mask == `MPES_UM_40
      |=> hit_r == $past(mem_ev.ld_retired))
    else $error("retired load count mismatch");
  all_stores_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_MEMUOP && unit_mask == `MPES_UM_80
      |=> hit_r == $past(mem_ev.st_retired))
    else $error("retired store count mismatch");
  dwalk_cyc_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_WALK && unit_mask == `MPES_UM_01
      && mem_ev.dwalk_busy |=> hit_r)
    else $error("data walk cycle not counted");
  iwalk_cyc_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_WALK && unit_mask == `MPES_UM_02
      && mem_ev.iwalk_busy |=> hit_r)
    else $error("instruction walk cycle not counted");
  cache_miss_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_L2CACHE && unit_mask == `MPES_UM_41
      && mem_ev.l2_miss |=> hit_r)
    else $error("second-level miss not counted");
  cache_ref_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_L2CACHE && unit_mask == `MPES_UM_4F
      && mem_ev.l2_ref |=> hit_r)
    else $error("second-level reference not counted");
  xq_count_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_XQREJ && unit_mask == `MPES_UM_00
      && xq_rej_r |=> hit_r)
    else $error("outer queue reject not counted");
  l2q_count_a: assert property (count_en && !edge_det
      && event_code == `MPES_EV_L2QREJ && unit_mask == `MPES_UM_00
      && l2q_rej_r |=> hit_r)
    else $error("shared queue reject not counted");

endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the memory pipeline event select block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import mpes_pkg::*;
  logic mclk, resetn, edge_det, count_en, count_clr, ev_on, hit_r;
  logic xq_issue, rq_park, rq_done, l2q_rej_r, xq_rej_r;
  logic [7:0] event_code, unit_mask;
  logic [4:0] ev_idx;
  logic [47:0] count_r;
  mpes_mem_ev_s mem_ev;
  mpes_req_s req, req_cmd;
  mpes_done_s done, done_cmd;
  mpes_lvl_t l2q_lvl_r, xq_lvl_r, rq_lvl_r;
  int num_errors = 0;
  int comparisons = 0;
  int hits = 0;
  int rejs = 0;
  // request encodings {valid,core,dirty,conflict,l2_pf,direct_xq}
  localparam mpes_req_s r_c0 = 6'b100000;
  localparam mpes_req_s r_c1 = 6'b110000;
  localparam mpes_req_s r_pf1 = 6'b110010;
  localparam mpes_req_s r_dc = 6'b101100;
  localparam mpes_req_s r_dx1 = 6'b110001;
  localparam mpes_done_s d_miss0 = 3'b101;

  mpes_top dut (.mclk, .resetn, .event_code, .unit_mask, .edge_det,
    .count_en, .count_clr, .mem_ev, .req, .done, .xq_issue, .rq_park,
    .rq_done, .count_r, .hit_r, .l2q_rej_r, .xq_rej_r, .l2q_lvl_r,
    .xq_lvl_r, .rq_lvl_r);

  mpes_src_model src (.mclk, .resetn, .ev_idx, .ev_on, .req_cmd,
    .done_cmd, .mem_ev, .req, .done);

  // 125 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // hit pulses counted mid-cycle, where they are settled
  always @(negedge mclk)
  begin
    if (hit_r === 1'b1) hits++;
    if (l2q_rej_r === 1'b1) rejs++;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [47:0] exp,
                       input logic [47:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
  endtask

  // program a selection and clear the counter in one go
  task automatic select(input logic [7:0] c, input logic [7:0] m,
                        input logic e);
    @(posedge mclk);
    event_code <= c;
    unit_mask <= m;
    edge_det <= e;
    count_clr <= 1'b1;
    @(posedge mclk);
    count_clr <= 1'b0;
  endtask

  // condition held n cycles, then time for the count to land
  task automatic strobe(input int idx, input int n);
    @(posedge mclk);
    ev_idx <= 5'(idx);
    ev_on <= 1'b1;
    repeat (n) @(posedge mclk);
    ev_on <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  task automatic q(input mpes_req_s r, input mpes_done_s d, input int n);
    @(posedge mclk);
    req_cmd <= r;
    done_cmd <= d;
    repeat (n) @(posedge mclk);
    req_cmd <= '0;
    done_cmd <= '0;
    repeat (4) @(posedge mclk);
  endtask

  // {xq_issue, rq_park, rq_done} held n cycles
  task automatic pulse3(input logic [2:0] v, input int n);
    @(posedge mclk);
    {xq_issue, rq_park, rq_done} <= v;
    repeat (n) @(posedge mclk);
    {xq_issue, rq_park, rq_done} <= 3'b000;
    repeat (4) @(posedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // each single-strobe code and mask pair counts its own strobe and not the next one's
  task automatic t_table();
    logic [7:0] mk [20] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
      8'h40, 8'h80, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40,
      8'h80, 8'h01, 8'h02, 8'h41, 8'h4f};
    for (int i = 0; i < 20; i++)
    begin
      select(i < 8 ? 8'h03 : i < 16 ? 8'h04 : i < 18 ? 8'h05 : 8'h2e,
             mk[i], 1'b0);
      strobe(i, 3);
      if (i < 8)
        check("retry ev", 48'd3, count_r);
      else if (i < 16)
        check("uop ev", 48'd3, count_r);
      else
        check("walk cache ev", 48'd3, count_r);
      strobe((i + 1) % 20, 2);
      check("other ev", 48'd3, count_r);
    end
    select(8'h77, 8'h01, 1'b0);
    strobe(0, 2);
    check("unknown code", 48'd0, count_r);
  endtask

  // walk cycles against walk counts through edge detect
  task automatic t_edge();
    int h;
    select(8'h05, 8'h03, 1'b1);
    h = hits;
    strobe(16, 5);
    check("walk edges", 48'd1, count_r);
    check("hit pulses", 48'd1, 48'(hits - h));
    strobe(17, 4);
    check("walk edges", 48'd2, count_r);
    select(8'h05, 8'h03, 1'b0);
    strobe(16, 5);
    check("walk cycles", 48'd5, count_r);
    select(8'h05, 8'h01, 1'b1);
    strobe(16, 5);
    check("d walks", 48'd1, count_r);
    select(8'h05, 8'h02, 1'b0);
    strobe(17, 2);
    strobe(17, 3);
    check("i walk cycles", 48'd5, count_r);
    count_en <= 1'b0;
    strobe(17, 3);
    check("disabled", 48'd5, count_r);
    count_en <= 1'b1;
  endtask

  // fairness, full shared queue and silent prefetch drops
  task automatic t_share();
    do_reset();
    select(8'h31, 8'h00, 1'b0);
    q(r_c0, '0, 13);
    check("share lvl", 48'd12, 48'(l2q_lvl_r));
    check("share rej", 48'd1, count_r);
    q(r_c1, '0, 3);
    check("other core", 48'd15, 48'(l2q_lvl_r));
    q(r_c1, '0, 1);
    check("full rej", 48'd2, count_r);
    q(r_pf1, '0, 1);
    check("pf silent", 48'd2, count_r);
    check("full lvl", 48'd15, 48'(l2q_lvl_r));
    do_reset();
    select(8'h31, 8'h00, 1'b0);
    q(r_dc, '0, 1);
    check("conflict rej", 48'd1, count_r);
    check("conflict lvl", 48'd0, 48'(l2q_lvl_r));
  endtask

  // misses move into the outer queue until it nears full
  task automatic t_outer();
    int r;
    do_reset();
    select(8'h30, 8'h00, 1'b0);
    q(r_c0, '0, 8);
    q('0, d_miss0, 6);
    check("xq fill", 48'd6, 48'(xq_lvl_r));
    check("l2q left", 48'd2, 48'(l2q_lvl_r));
    q('0, d_miss0, 1);
    check("xq rej", 48'd1, count_r);
    check("entry kept", 48'd2, 48'(l2q_lvl_r));
    r = rejs;
    q(r_dx1, '0, 1);
    check("direct rej", 48'd2, 48'(l2q_lvl_r));
    check("direct pulse", 48'd1, 48'(rejs - r));
    pulse3(3'b100, 1);
    check("xq issue", 48'd5, 48'(xq_lvl_r));
    q('0, d_miss0, 1);
    check("xq move", 48'd6, 48'(xq_lvl_r));
    check("l2q move", 48'd1, 48'(l2q_lvl_r));
    // with room again a direct request lands in the outer queue
    pulse3(3'b100, 2);
    q(r_dx1, '0, 1);
    check("direct entry", 48'd5, 48'(xq_lvl_r));
  endtask

  // retry queue keeps ops until reissued and complete
  task automatic t_retry();
    do_reset();
    pulse3(3'b010, 3);
    pulse3(3'b001, 1);
    check("rq lvl", 48'd2, 48'(rq_lvl_r));
    pulse3(3'b010, 10);
    check("rq full", 48'd8, 48'(rq_lvl_r));
    pulse3(3'b001, 10);
    check("rq empty", 48'd0, 48'(rq_lvl_r));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    {edge_det, count_clr, ev_on, xq_issue, rq_park, rq_done} = '0;
    count_en = 1'b1;
    {event_code, unit_mask, ev_idx} = '0;
    req_cmd = '0;
    done_cmd = '0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    check("reset count", 48'd0, count_r);
    t_table();
    t_edge();
    t_share();
    t_outer();
    t_retry();
    complete_run();
  end

  // hang guard, about thirty times the expected run length
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    complete_run();
  end
endmodule

`default_nettype wire
